/* File: rtl/cat_ctrl.sv */
// Auto tuning controller for one capacitive channel.
// Assumes the front end gives a count and a one-cycle sample valid
// on ref_clk; settings apply from the next sample onward.
//
// Contract
// - Tune after every start-up and whenever count leaves the window.
// - Step coarse gain first so the count approaches the base value.
// - Then step fine offset until the count comes within 4 of target 1600.
// - Base select bits 2:1: 00=200, 01=100, 10=150, 11=250.
// - Target stays fixed at 1600 whatever base is chosen.
// - While tuning, busy is reported and detection is blocked.
// - Only the start bit or a large count shift starts re-tuning; small drift does not.
`timescale 1ns/100ps
module cat_ctrl #(
  parameter int CNT_W = 16
) (
  input  wire logic             ref_clk,      // 50 MHz clock
  input  wire logic             rst_n,        // Sync reset, active low
  input  wire logic [3:0]       reg_addr,     // Register address
  input  wire logic [15:0]      reg_wdata,    // Write data
  input  wire logic             reg_wr,       // Write strobe
  input  wire logic             reg_rd,       // Read strobe
  output logic      [15:0]      reg_rdata,    // Read data, next cycle
  input  wire logic             sample_valid, // New count pulse
  input  wire logic [CNT_W-1:0] sample_count, // Measured count
  output cat_pkg::cat_settings_t settings,    // Gain and offset to AFE
  output logic                  tuning_busy,  // Streamed busy status
  output logic                  detect_enable,// Detection allowed
  output logic                  irq           // Interrupt level
);

  // ****************************************
  // State
  // ****************************************
  cat_pkg::cat_state_t   state;
  cat_pkg::cat_state_t   next_state;
  cat_pkg::cat_settings_t next_settings;
  logic [2:0]            ctrl;
  logic [2:0]            next_ctrl;
  logic [15:0]           window;
  logic [15:0]           next_window;
  logic [15:0]           last_count;
  logic [15:0]           next_last_count;
  logic                  boot;
  logic                  next_boot;
  logic                  next_detect;
  logic [15:0]           next_rdata;
  logic [15:0]           base;
  logic [15:0]           cnt;
  logic                  out_of_range;
  logic                  ev_done;
  logic                  ev_start;
  logic [cat_pkg::IRQ_W-1:0] irq_status;
  logic [cat_pkg::IRQ_W-1:0] irq_mask;
  logic [cat_pkg::IRQ_W-1:0] irq_clr;
  logic                  start_req;

  assign cnt = 16'(sample_count);

  // ****************************************
  // Base value selection
  // ****************************************
  always_comb begin
    case (ctrl[cat_pkg::CTRL_BASE_HI:cat_pkg::CTRL_BASE_LO])
      2'h0:    base = cat_pkg::BASE_CODE0;
      2'h1:    base = cat_pkg::BASE_CODE1;
      2'h2:    base = cat_pkg::BASE_CODE2;
      default: base = cat_pkg::BASE_CODE3;
    endcase
  end

  // Wide window only; small drift is ignored
  assign out_of_range =
    (cnt > cat_pkg::TUNING_TARGET + window) ||
    (cnt + window < cat_pkg::TUNING_TARGET);

  assign start_req = reg_wr && (reg_addr == cat_pkg::ADDR_CTRL) &&
                     reg_wdata[cat_pkg::CTRL_START_BIT];

  // ****************************************
  // Tuning sequence
  // ****************************************
  always_comb begin
    next_state    = state;
    next_settings = settings;
    next_boot     = boot;
    next_detect   = detect_enable;
    ev_done       = 1'b0;
    ev_start      = 1'b0;
    case (state)
      cat_pkg::CAT_RUN: begin
        if (boot || start_req ||
            (sample_valid && out_of_range)) begin
          next_state  = cat_pkg::CAT_COARSE;
          next_boot   = 1'b0;
          next_detect = 1'b0;
          next_settings.coarse_gain_setting = cat_pkg::GAIN_RESET;
          next_settings.fine_offset_setting = cat_pkg::OFFSET_RESET;
          ev_start    = 1'b1;
        end
      end
      cat_pkg::CAT_COARSE: begin
        // Raw count scales with gain; step until near base
        if (sample_valid) begin
          if (cnt + cat_pkg::BASE_TOL < base &&
              settings.coarse_gain_setting != 3'h7) begin
            next_settings.coarse_gain_setting =
              settings.coarse_gain_setting + 3'h1;
          end else begin
            next_state = cat_pkg::CAT_FINE;
          end
        end
      end
      cat_pkg::CAT_FINE: begin
        if (sample_valid) begin
          if (cnt + cat_pkg::TARGET_TOL < cat_pkg::TUNING_TARGET &&
              settings.fine_offset_setting != 6'h3F) begin
            next_settings.fine_offset_setting =
              settings.fine_offset_setting + 6'h01;
          end else begin
            next_state = cat_pkg::CAT_SETTLE;
            ev_done    = 1'b1;
          end
        end
      end
      cat_pkg::CAT_SETTLE: begin
        // Detection resumes on the next measurement
        if (sample_valid) begin
          next_state  = cat_pkg::CAT_RUN;
          next_detect = 1'b1;
        end
      end
      default: next_state = cat_pkg::CAT_RUN;
    endcase
  end

  // ****************************************
  // Register port
  // ****************************************
  always_comb begin
    next_ctrl       = ctrl;
    next_window     = window;
    next_last_count = sample_valid ? cnt : last_count;
    irq_clr         = '0;
    next_rdata      = 16'h0000;
    if (reg_wr) begin
      case (reg_addr)
        cat_pkg::ADDR_CTRL:
          next_ctrl = {reg_wdata[cat_pkg::CTRL_BASE_HI:
                                 cat_pkg::CTRL_BASE_LO], 1'b0};
        cat_pkg::ADDR_WINDOW:   next_window = reg_wdata;
        cat_pkg::ADDR_IRQ_STAT: irq_clr = reg_wdata[cat_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        cat_pkg::ADDR_CTRL:     next_rdata = {13'h0000, ctrl};
        cat_pkg::ADDR_STATUS:
          next_rdata = {12'h000, 2'(state), detect_enable, tuning_busy};
        cat_pkg::ADDR_SETTINGS: next_rdata = {7'h00, settings};
        cat_pkg::ADDR_COUNT:    next_rdata = last_count;
        cat_pkg::ADDR_IRQ_STAT: next_rdata = {14'h0000, irq_status};
        cat_pkg::ADDR_IRQ_MASK: next_rdata = {14'h0000, irq_mask};
        cat_pkg::ADDR_WINDOW:   next_rdata = window;
        default:                next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state         <= cat_pkg::CAT_RUN;
      settings      <= '0;
      boot          <= 1'b1;
      detect_enable <= 1'b0;
      ctrl          <= cat_pkg::CTRL_RESET;
      window        <= cat_pkg::WINDOW_RESET;
      last_count    <= 16'h0000;
      reg_rdata     <= 16'h0000;
    end else begin
      state         <= next_state;
      settings      <= next_settings;
      boot          <= next_boot;
      detect_enable <= next_detect;
      ctrl          <= next_ctrl;
      window        <= next_window;
      last_count    <= next_last_count;
      reg_rdata     <= next_rdata;
    end
  end

  assign tuning_busy = (state != cat_pkg::CAT_RUN) &&
                       (state != cat_pkg::CAT_SETTLE);

  // ****************************************
  // Interrupts
  // ****************************************
  cat_irq #(
    .W(cat_pkg::IRQ_W)
  ) u_irq (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .event_in ({ev_start, ev_done}),
    .clr_in   (irq_clr),
    .mask_we  (reg_wr && reg_addr == cat_pkg::ADDR_IRQ_MASK),
    .mask_in  (reg_wdata[cat_pkg::IRQ_W-1:0]),
    .status   (irq_status),
    .mask     (irq_mask),
    .irq      (irq)
  );

endmodule : cat_ctrl

/* File: rtl/cat_irq.sv */
// Sticky interrupt status with mask and one level output.
// Assumes same clock domain events; write one clears.
`timescale 1ns/100ps
module cat_irq #(
  parameter int W = 2
) (
  input  wire logic         ref_clk,   // Clock
  input  wire logic         rst_n,     // Sync reset, active low
  input  wire logic [W-1:0] event_in,  // Event pulses
  input  wire logic [W-1:0] clr_in,    // Write-one-to-clear bits
  input  wire logic         mask_we,   // Mask write strobe
  input  wire logic [W-1:0] mask_in,   // Mask write data
  output logic      [W-1:0] status,    // Sticky status
  output logic      [W-1:0] mask,      // Mask register
  output logic              irq        // Level interrupt
);

  logic [W-1:0] next_status;
  logic [W-1:0] next_mask;

  always_comb begin
    next_mask = mask_we ? mask_in : mask;
    for (int i = 0; i < W; i++) begin
      // Set beats clear
      next_status[i] = event_in[i] | (status[i] & ~clr_in[i]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status <= '0;
      mask   <= '0;
    end else begin
      status <= next_status;
      mask   <= next_mask;
    end
  end

  assign irq = |(status & mask);

endmodule : cat_irq

/* File: rtl/cat_pkg.sv */
// Package for the capacitive auto tuning controller.
// Assumes a single 50 MHz clock domain and a plain register port.
package cat_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h1;
  localparam logic [3:0] ADDR_SETTINGS = 4'h2;
  localparam logic [3:0] ADDR_COUNT    = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
  localparam logic [3:0] ADDR_WINDOW   = 4'h6;

  // Control fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_BASE_LO   = 1;
  localparam int CTRL_BASE_HI   = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Interrupt bits
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_START_BIT = 1;
  localparam int IRQ_W         = 2;

  // ****************************************
  // Tuning constants
  // ****************************************
  localparam logic [15:0] TUNING_TARGET = 16'h0640;
  localparam logic [15:0] BASE_CODE0    = 16'h00C8;
  localparam logic [15:0] BASE_CODE1    = 16'h0064;
  localparam logic [15:0] BASE_CODE2    = 16'h0096;
  localparam logic [15:0] BASE_CODE3    = 16'h00FA;
  localparam logic [15:0] WINDOW_RESET  = 16'h0190;
  localparam logic [15:0] BASE_TOL      = 16'h0008;
  localparam logic [15:0] TARGET_TOL    = 16'h0004;
  localparam logic [2:0]  GAIN_RESET    = 3'h0;
  localparam logic [5:0]  OFFSET_RESET  = 6'h00;

  typedef enum logic [1:0] {
    CAT_RUN,
    CAT_COARSE,
    CAT_FINE,
    CAT_SETTLE
  } cat_state_t;

  typedef struct packed {
    logic [2:0] coarse_gain_setting;
    logic [5:0] fine_offset_setting;
  } cat_settings_t;

endpackage : cat_pkg

/* File: testbench/cat_afe_model.sv */
// Front end model: count follows gain, offset and a drift input.
// Assumes settings come from cat_ctrl; one sample every 4 clocks.
`timescale 1ns/100ps
module cat_afe_model (
  input  wire logic                   ref_clk,              // Clock
  input  wire logic                   rst_n,                // Sync reset
  input  wire cat_pkg::cat_settings_t settings,             // Tuning
  input  wire logic [15:0]            env,                  // Drift
  output logic                        sample_valid = 1'b0,  // Pulse
  output logic [15:0]                 sample_count          // Count
);
  logic [1:0] div = 2'h0;
  always @(posedge ref_clk) begin
    div <= rst_n ? div + 2'h1 : 2'h0;
    sample_valid <= rst_n && (div == 2'h3);
  end
  assign sample_count = 16'h0028 + 16'h0028 * settings.coarse_gain_setting
                      + 16'h0019 * settings.fine_offset_setting + env;
endmodule : cat_afe_model

/* File: testbench/cat_ctrl_asserts.sv */
// Checker for cat_ctrl, bound at its ports.
// Assumes the window register keeps its reset value.
`timescale 1ns/100ps
module cat_ctrl_chk #(
  parameter int CNT_W = 16
) (
  input wire logic                   ref_clk,        // Clock
  input wire logic                   rst_n,          // Reset
  input wire logic                   reg_wr,         // Write strobe
  input wire logic                   sample_valid,   // Sample pulse
  input wire logic [CNT_W-1:0]       sample_count,   // Count
  input wire cat_pkg::cat_settings_t settings,       // Settings
  input wire logic                   tuning_busy,    // Busy
  input wire logic                   detect_enable   // Detect
);
  wire [2:0] gain = settings.coarse_gain_setting;
  wire [5:0] offs = settings.fine_offset_setting;
  wire in_win = sample_count >= 1200 && sample_count <= 2000;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_done;
    $fell(tuning_busy);
  endsequence
  busy_no_detect_a:
    assert property (tuning_busy |-> !detect_enable)
    else $error("detection open while tuning");
  detect_on_sample_a:
    assert property ($rose(detect_enable) |-> $past(sample_valid))
    else $error("detection opened without a sample");
  idle_hold_a:
    assert property (!tuning_busy && !$past(tuning_busy) |-> $stable(settings))
    else $error("settings moved while idle");
  step_on_sample_a:
    assert property ($changed(settings) && settings != 9'h0
                     |-> $past(sample_valid))
    else $error("settings stepped without a sample");
  gain_step_a:
    assert property ($changed(gain) && gain != 3'h0
                     |-> gain == $past(gain) + 3'h1)
    else $error("gain step not one");
  offset_step_a:
    assert property ($changed(offs) && offs != 6'h0
                     |-> offs == $past(offs) + 6'h1 && $stable(gain))
    else $error("offset step wrong");
  stop_target_a:
    assert property (s_done and $past(offs) != 6'h3F
                     |-> $past(sample_count) + 16'h0004 >= cat_pkg::TUNING_TARGET)
    else $error("tuning ended short of target");
  retune_a:
    assert property (sample_valid && !tuning_busy && detect_enable
                     && sample_count > 2000 |=> tuning_busy)
    else $error("no re-tune on large shift");
  small_drift_a:
    assert property (sample_valid && !tuning_busy && detect_enable && in_win
                     && !reg_wr |=> !tuning_busy)
    else $error("re-tune on small drift");
endmodule : cat_ctrl_chk
bind cat_ctrl cat_ctrl_chk #(.CNT_W(CNT_W)) i_cat_ctrl_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr),
  .sample_valid(sample_valid), .sample_count(sample_count),
  .settings(settings), .tuning_busy(tuning_busy),
  .detect_enable(detect_enable));

/* File: testbench/testbench.sv */
// Self-checking bench for cat_ctrl with a front end model.
// Assumes cat_pkg and the checker are compiled first.
`timescale 1ns/100ps
module testbench;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] env = 16'h0000;
  logic [15:0] reg_rdata, sample_count, d;
  logic        sample_valid, tuning_busy, detect_enable, irq;
  cat_pkg::cat_settings_t settings;
  int          fail_count = 0;
  int          checked = 0;
  int          n;
  // Rows: base code, final gain, final offset
  logic [10:0] rows [4] = '{{2'h0, 3'h4, 6'h38}, {2'h1, 3'h2, 6'h3C},
                            {2'h2, 3'h3, 6'h3A}, {2'h3, 3'h6, 6'h35}};
  always #10 ref_clk = ~ref_clk;
  cat_ctrl i_cat_ctrl (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
    .sample_count(sample_count), .settings(settings),
    .tuning_busy(tuning_busy), .detect_enable(detect_enable), .irq(irq));
  cat_afe_model i_cat_afe_model (.ref_clk(ref_clk), .rst_n(rst_n),
    .settings(settings), .env(env), .sample_valid(sample_valid),
    .sample_count(sample_count));
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [15:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic wt(logic v);
    n = 0;
    while (tuning_busy !== v && n < 1000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk("busy", 16'(v), 16'(tuning_busy));
  endtask : wt
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1 chk("boot busy", 16'h1, 16'(tuning_busy));
    chk("boot detect", 16'h0, 16'(detect_enable));
    chk("irq masked", 16'h0, 16'(irq));
    wt(1'b0);
    // Start is only taken in RUN, so let the settle sample pass first
    repeat (5) @(posedge ref_clk);
    #1 chk("boot detect on", 16'h1, 16'(detect_enable));
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      wr(cat_pkg::ADDR_CTRL, {13'h0, rows[i][10:9], 1'b1});
      wt(1'b1);
      wt(1'b0);
      chk("detect at end", 16'h0, 16'(detect_enable));
      chk("settings", {7'h0, rows[i][8:0]}, 16'(settings));
      rd(cat_pkg::ADDR_COUNT);
      chk("count", 16'd40 + 16'd40 * rows[i][8:6] + 16'd25 * rows[i][5:0],
          d);
      repeat (5) @(posedge ref_clk);
      #1 chk("detect after", 16'h1, 16'(detect_enable));
      $display("row %0d done", i);
    end
    wr(cat_pkg::ADDR_IRQ_MASK, 16'h0001);
    @(posedge ref_clk);
    #1 chk("irq raised", 16'h1, 16'(irq));
    wr(cat_pkg::ADDR_IRQ_STAT, 16'h0003);
    rd(cat_pkg::ADDR_IRQ_STAT);
    chk("irq status", 16'h0, d);
    chk("irq cleared", 16'h0, 16'(irq));
    rd(4'hF);
    chk("unmapped", 16'h0, d);
    rd(cat_pkg::ADDR_STATUS);
    chk("status", 16'h0002, d);
    rd(cat_pkg::ADDR_WINDOW);
    chk("window", 16'h0190, d);
    $display("register test done");
    @(posedge ref_clk);
    env <= 16'd100;
    repeat (20) @(posedge ref_clk);
    #1 chk("small drift", 16'h0, 16'(tuning_busy));
    @(posedge ref_clk);
    env <= 16'd500;
    wt(1'b1);
    wt(1'b0);
    chk("retuned", 16'h002B, 16'(settings));
    $display("drift test done");
    end_of_test();
  end
endmodule : testbench
